// *** task_file_pkg.sv ***
// Purpose: Shared constants and types of the task-file address decoder.
// Assumes: Offsets are the four-bit task-file offsets seen by the host.
// Notes:   Bit positions are typed int; register values are sized.

package task_file_pkg;

   typedef enum logic [2:0] {
      MODE_MEM = 3'b001,
      MODE_IO  = 3'b010,
      MODE_IDE = 3'b100
   } card_mode_t;

   localparam logic [1:0] LANE_NONE = 2'b00;
   localparam logic [1:0] LANE_LOW  = 2'b01;
   localparam logic [1:0] LANE_HIGH = 2'b10;
   localparam logic [1:0] LANE_WORD = 2'b11;

   localparam logic [3:0] OFF_DATA        = 4'h0;
   localparam logic [3:0] OFF_FAULT       = 4'h1;
   localparam logic [3:0] OFF_COUNT       = 4'h2;
   localparam logic [3:0] OFF_SECTOR      = 4'h3;
   localparam logic [3:0] OFF_CYL_LOW     = 4'h4;
   localparam logic [3:0] OFF_CYL_HIGH    = 4'h5;
   localparam logic [3:0] OFF_HEAD        = 4'h6;
   localparam logic [3:0] OFF_COMMAND     = 4'h7;
   localparam logic [3:0] OFF_EVEN        = 4'h8;
   localparam logic [3:0] OFF_ODD         = 4'h9;
   localparam logic [3:0] OFF_FAULT_ALIAS = 4'hd;
   localparam logic [3:0] OFF_SHADOW      = 4'he;
   localparam logic [3:0] OFF_UNIT        = 4'hf;

   localparam logic [2:0] MEM_DATA_BASE   = 3'b100;
   localparam logic [1:0] IDE_CTRL_ADDR   = 2'b11;
   localparam logic [2:0] IDE_CTRL_BASE   = 3'b111;

   localparam int ERR_BAD_BLOCK = 7;
   localparam int ERR_UNCORR    = 6;
   localparam int ERR_ID_MISS   = 4;
   localparam int ERR_ABORT     = 2;
   localparam int ERR_GENERAL   = 0;
   localparam int HEAD_BLOCK    = 6;
   localparam int HEAD_DRIVE    = 4;
   localparam int CTL_SOFT_RST  = 2;
   localparam int CTL_INT_OFF   = 1;

   localparam logic [7:0] HEAD_RESET   = 8'ha0;
   localparam logic [7:0] CTL_RESET    = 8'h00;
   localparam logic [7:0] UNMAPPED_RD  = 8'h00;
   localparam logic [8:0] FULL_COUNT   = 9'h100;

endpackage

// *** task_file_address_decoder.sv ***
// Purpose: Task-file decode, lane steering and the task-file registers.
// Assumes: Host strobes, selects and data are synchronous to sys_clk.
// Notes:   An access acts on the first cycle its strobe is seen low.
//
// What this block does
// - I/O mode with select low maps A3..A0 onto the sixteen offsets.
// - Memory mode ignores A9..A4; with A10 high A0 picks even or odd data.
// - True IDE decodes A2..A0 as offsets 0-7, or control block at 110 and 111.
// - True IDE DMA grant with both selects high moves a data word.
// - A 16-bit data port reaches the buffer at offsets 0, 8 and 9.
// - Byte enables choose word, low byte by A0, or odd byte high.
// - Fault detail is read at 1 and D, valid when ERR is set.
// - High-lane-only read at offset 0 returns fault detail on D15-D8.
// - Writes at 1, D, or high lane at 0 load command option.
// - Bit 7 of fault detail marks bad block or interface CRC error.
// - Bits 6, 4 and 0 mark uncorrectable, missing sector, general error.
// - Bit 2 marks an aborted or invalid command.
// - Fault detail bits 5, 3 and 1 always read zero.
// - A block count of zero means 256 blocks.
// - Success leaves the count at zero; failure leaves sectors remaining.
// - Sector register is the start sector or address bits 7-0.
// - Cylinder low is cylinder low byte or address bits 15-8.
// - Cylinder high is cylinder high byte or address bits 23-16.
// - Head register bit 6 picks cylinder/head/sector or block addressing.
// - Status bit 0 is set when the last command ended in error.
// - Status read clears a pending interrupt; shadow read does not.

`timescale 1ns/10ps
`default_nettype none

module task_file_address_decoder
   import task_file_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       srst,
   input  wire card_mode_t card_mode,
   input  wire logic       reg_select_n,
   input  wire logic [10:0] addr,
   input  wire logic       low_byte_enable_n,
   input  wire logic       high_byte_enable_n,
   input  wire logic       io_read_strobe_n,
   input  wire logic       io_write_strobe_n,
   input  wire logic       mem_read_strobe_n,
   input  wire logic       mem_write_strobe_n,
   input  wire logic       command_block_select_n,
   input  wire logic       control_block_select_n,
   input  wire logic       dma_grant_n,
   input  wire logic [15:0] data_in,
   input  wire logic       pio_byte_mode,
   input  wire logic [15:0] buf_rd_data,
   input  wire logic [5:0] device_flags,
   input  wire logic       write_gate,
   input  wire logic       bad_block_or_crc_flag,
   input  wire logic       uncorrectable_flag,
   input  wire logic       sector_id_missing_flag,
   input  wire logic       command_aborted_flag,
   input  wire logic       general_error_flag,
   input  wire logic       command_done,
   input  wire logic       command_failed,
   input  wire logic [7:0] remaining_sectors,
   input  wire logic       interrupt_event,
   output logic [15:0]     data_out,
   output logic            data_oe_low,
   output logic            data_oe_high,
   output logic [15:0]     buf_wr_data,
   output logic            buf_wr_valid,
   output logic            buf_rd_pop,
   output logic [7:0]      command_code,
   output logic            command_valid,
   output logic [7:0]      command_option,
   output logic [8:0]      transfer_sectors,
   output logic [27:0]     start_address,
   output logic            logical_block_mode,
   output logic            unit_select,
   output logic            soft_reset,
   output logic            interrupt_request
);

   typedef struct packed {
      logic       hit;
      logic [1:0] lane;
      logic [3:0] off;
   } dec_t;

   typedef struct packed {
      logic [15:0] data_out;
      logic        oe_low;
      logic        oe_high;
      logic        rd_seen;
      logic        wr_seen;
      logic        phase;
      logic [7:0]  even_hold;
      logic [15:0] wr_data;
      logic        wr_valid;
      logic        rd_pop;
      logic [7:0]  option;
      logic [7:0]  count;
      logic [7:0]  sector;
      logic [7:0]  cyl_low;
      logic [7:0]  cyl_high;
      logic [7:0]  head;
      logic [7:0]  control;
      logic [7:0]  fault;
      logic        err_flag;
      logic        int_pending;
      logic        irq;
      logic [7:0]  command;
      logic        cmd_valid;
      logic [8:0]  sectors;
      logic [27:0] address;
      logic        soft_rst;
   } state_t;

   function automatic dec_t decode(
      input card_mode_t  m,
      input logic        rs_n,
      input logic [10:0] a,
      input logic        lo_n,
      input logic        hi_n,
      input logic        cmd_n,
      input logic        ctl_n,
      input logic        ack_n,
      input logic        byte_mode
   );
      dec_t       d;
      logic [3:0] base;
      logic       space_ok;
      d        = '{hit: 1'b0, lane: LANE_NONE, off: OFF_DATA};
      base     = a[3:0];
      space_ok = 1'b0;
      if (m == MODE_IDE) begin
         if (!ack_n && cmd_n && ctl_n) begin
            d.hit  = 1'b1;
            d.lane = LANE_WORD;
         end else if (ack_n && ctl_n && !cmd_n) begin
            d.hit  = 1'b1;
            d.off  = {1'b0, a[2:0]};
            d.lane = LANE_LOW;
            if (a[2:0] == OFF_DATA[2:0] && !byte_mode) begin
               d.lane = LANE_WORD;
            end
         end else if (ack_n && !ctl_n && cmd_n && a[2:1] == IDE_CTRL_ADDR) begin
            d.hit  = 1'b1;
            d.off  = {IDE_CTRL_BASE, a[0]};
            d.lane = LANE_LOW;
         end
      end else begin
         // Memory space wants register select high, I/O space low.
         space_ok = (m == MODE_IO && !rs_n) || (m == MODE_MEM && rs_n);
         if (m == MODE_MEM && a[10]) begin
            base = {MEM_DATA_BASE, a[0]};
         end
         case ({hi_n, lo_n})
            2'b00: begin
               d.lane = LANE_WORD;
               d.off  = {base[3:1], 1'b0};
            end
            2'b10: begin
               d.lane = LANE_LOW;
               d.off  = base;
            end
            2'b01: begin
               d.lane = LANE_HIGH;
               d.off  = {base[3:1], 1'b1};
            end
            default: begin
               d.lane = LANE_NONE;
            end
         endcase
         d.hit = space_ok && d.lane != LANE_NONE;
      end
      return d;
   endfunction

   state_t     s;
   state_t     n;
   dec_t       d;
   logic       rd_low;
   logic       wr_low;
   logic       rd_go;
   logic       wr_go;
   logic       is_data;
   logic       odd;
   logic       busy;
   logic [3:0] tgt;
   logic [7:0] rb;
   logic [7:0] wb;
   logic [7:0] pick;
   logic [7:0] status;

   always_comb begin
      n      = s;
      rd_low = (card_mode == MODE_MEM) ? !mem_read_strobe_n : !io_read_strobe_n;
      wr_low = (card_mode == MODE_MEM) ? !mem_write_strobe_n : !io_write_strobe_n;
      d      = decode(card_mode, reg_select_n, addr, low_byte_enable_n,
                      high_byte_enable_n, command_block_select_n,
                      control_block_select_n, dma_grant_n, pio_byte_mode);
      rd_go  = rd_low && !s.rd_seen && d.hit;
      wr_go  = wr_low && !s.wr_seen && d.hit;
      busy   = device_flags[5];
      status = {device_flags, 1'b0, s.err_flag};
      is_data = d.off == OFF_DATA || d.off == OFF_EVEN || d.off == OFF_ODD;
      odd    = d.off == OFF_ODD || (card_mode == MODE_IDE && s.phase);
      pick   = odd ? buf_rd_data[15:8] : buf_rd_data[7:0];
      tgt    = d.off;
      rb     = UNMAPPED_RD;
      wb     = 8'h00;
      n.rd_seen   = rd_low;
      n.wr_seen   = wr_low;
      n.rd_pop    = 1'b0;
      n.wr_valid  = 1'b0;
      n.cmd_valid = 1'b0;
      if (!rd_low) begin
         n.oe_low  = 1'b0;
         n.oe_high = 1'b0;
      end

      if (rd_go) begin
         n.oe_low   = d.lane[0];
         n.oe_high  = d.lane[1];
         n.data_out = 16'h0000;
         if (is_data) begin
            if (d.lane == LANE_WORD) begin
               n.data_out = buf_rd_data;
               n.rd_pop   = 1'b1;
            end else begin
               // The odd byte completes the word and advances the buffer.
               n.data_out = {pick, pick};
               n.rd_pop   = odd;
               n.phase    = !s.phase;
            end
         end else begin
            for (int i = 0; i < 2; i++) begin
               tgt = (d.lane == LANE_WORD) ? {d.off[3:1], 1'(i)} : d.off;
               case (tgt)
                  OFF_FAULT, OFF_FAULT_ALIAS: rb = s.fault;
                  OFF_COUNT:    rb = s.count;
                  OFF_SECTOR:   rb = s.sector;
                  OFF_CYL_LOW:  rb = s.cyl_low;
                  OFF_CYL_HIGH: rb = s.cyl_high;
                  OFF_HEAD:     rb = s.head;
                  OFF_COMMAND: begin
                     rb = status;
                     if (d.lane[i]) begin
                        n.int_pending = 1'b0;
                     end
                  end
                  OFF_SHADOW:   rb = status;
                  OFF_UNIT: begin
                     rb = {1'b0, !write_gate, ~s.head[3:0],
                           ~s.head[HEAD_DRIVE], s.head[HEAD_DRIVE]};
                  end
                  default:      rb = UNMAPPED_RD;
               endcase
               n.data_out[8*i +: 8] = rb;
            end
         end
      end

      if (wr_go) begin
         if (is_data) begin
            if (d.lane == LANE_WORD) begin
               n.wr_data  = data_in;
               n.wr_valid = 1'b1;
            end else begin
               wb = (d.lane == LANE_HIGH) ? data_in[15:8] : data_in[7:0];
               if (odd) begin
                  n.wr_data  = {wb, s.even_hold};
                  n.wr_valid = 1'b1;
               end else begin
                  n.even_hold = wb;
               end
               n.phase = !s.phase;
            end
         end else begin
            for (int i = 0; i < 2; i++) begin
               tgt = (d.lane == LANE_WORD) ? {d.off[3:1], 1'(i)} : d.off;
               wb  = data_in[8*i +: 8];
               if (d.lane == LANE_HIGH) begin
                  wb = data_in[15:8];
               end
               // Only device control may be written while the card is busy.
               if (d.lane[i] && (!busy || tgt == OFF_SHADOW)) begin
                  case (tgt)
                     OFF_FAULT, OFF_FAULT_ALIAS: n.option = wb;
                     OFF_COUNT:    n.count    = wb;
                     OFF_SECTOR:   n.sector   = wb;
                     OFF_CYL_LOW:  n.cyl_low  = wb;
                     OFF_CYL_HIGH: n.cyl_high = wb;
                     OFF_HEAD:     n.head     = wb;
                     OFF_COMMAND: begin
                        n.command     = wb;
                        n.cmd_valid   = 1'b1;
                        n.fault       = 8'h00;
                        n.err_flag    = 1'b0;
                        n.int_pending = 1'b0;
                        n.phase       = 1'b0;
                     end
                     OFF_SHADOW:   n.control  = wb;
                     default: ;
                  endcase
               end
            end
         end
      end

      // Soft reset clears command results.
      if (s.control[CTL_SOFT_RST]) begin
         n.fault       = 8'h00;
         n.err_flag    = 1'b0;
         n.int_pending = 1'b0;
         n.phase       = 1'b0;
      end

      // Card events, applied last so a set beats a same-cycle clear.
      if (bad_block_or_crc_flag) begin
         n.fault[ERR_BAD_BLOCK] = 1'b1;
      end
      if (uncorrectable_flag) begin
         n.fault[ERR_UNCORR] = 1'b1;
      end
      if (sector_id_missing_flag) begin
         n.fault[ERR_ID_MISS] = 1'b1;
      end
      if (general_error_flag) begin
         n.fault[ERR_GENERAL] = 1'b1;
      end
      if (command_aborted_flag) begin
         n.fault[ERR_ABORT] = 1'b1;
      end
      n.fault[5] = 1'b0;
      n.fault[3] = 1'b0;
      n.fault[1] = 1'b0;
      if (command_done) begin
         if (command_failed) begin
            n.count    = remaining_sectors;
            n.err_flag = 1'b1;
         end else begin
            n.count = 8'h00;
         end
      end
      if (interrupt_event) begin
         n.int_pending = 1'b1;
      end

      // Values handed to the command engine.
      n.irq      = n.int_pending && !n.control[CTL_INT_OFF];
      n.soft_rst = n.control[CTL_SOFT_RST];
      n.sectors  = (n.count == 8'h00) ? FULL_COUNT : {1'b0, n.count};
      n.address  = {n.head[3:0], n.cyl_high, n.cyl_low, n.sector};
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         s         <= '0;
         s.head    <= HEAD_RESET;
         s.control <= CTL_RESET;
         s.sectors <= FULL_COUNT;
      end else begin
         s <= n;
      end
   end

   assign data_out           = s.data_out;
   assign data_oe_low        = s.oe_low;
   assign data_oe_high       = s.oe_high;
   assign buf_wr_data        = s.wr_data;
   assign buf_wr_valid       = s.wr_valid;
   assign buf_rd_pop         = s.rd_pop;
   assign command_code       = s.command;
   assign command_valid      = s.cmd_valid;
   assign command_option     = s.option;
   assign transfer_sectors   = s.sectors;
   assign start_address      = s.address;
   assign logical_block_mode = s.head[HEAD_BLOCK];
   assign unit_select        = s.head[HEAD_DRIVE];
   assign soft_reset         = s.soft_rst;
   assign interrupt_request  = s.irq;

endmodule

`default_nettype wire

// *** task_file_checker.sv ***
// Purpose: Port-level timing checks of the task-file decoder.
// Assumes: Host strobes stay high through reset.
// Notes:   Only I/O and True IDE strobes are watched.
`timescale 1ns/10ps
`default_nettype none
module task_file_checker
   import task_file_pkg::*;
(
   input wire logic        sys_clk, srst, reg_select_n, low_byte_enable_n, high_byte_enable_n,
   input wire logic        io_read_strobe_n, io_write_strobe_n, dma_grant_n,
   input wire logic        command_block_select_n, control_block_select_n,
   input wire logic        interrupt_event, command_done, command_failed, interrupt_request,
   input wire logic        data_oe_low, data_oe_high, buf_wr_valid, command_valid,
   input wire card_mode_t  card_mode,
   input wire logic [10:0] addr,
   input wire logic [15:0] data_in, data_out, buf_wr_data,
   input wire logic [5:0]  device_flags,
   input wire logic [7:0]  remaining_sectors, command_code,
   input wire logic [8:0]  transfer_sectors
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   logic io_lo;
   assign io_lo = card_mode == MODE_IO && !reg_select_n && !low_byte_enable_n;
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   a_count_read_drives: assert property ($fell(io_read_strobe_n) && io_lo
      && addr[3:0] == OFF_COUNT |=> data_oe_low) else $error("count read not driven");
   a_command_write_load: assert property ($fell(io_write_strobe_n) && io_lo && !device_flags[5]
      && addr[3:0] == OFF_COMMAND |=> command_valid
      && {8'h00, command_code} == ($past(data_in) & 16'h00ff)) else $error("command lost");
   a_no_enable_idle: assert property ($fell(io_read_strobe_n) && card_mode == MODE_IO
      && low_byte_enable_n && high_byte_enable_n |=> !data_oe_low && !data_oe_high)
      else $error("lanes driven without enable");
   a_dma_word_push: assert property ($fell(io_write_strobe_n) && card_mode == MODE_IDE
      && !dma_grant_n && command_block_select_n && control_block_select_n && !device_flags[5]
      |=> buf_wr_valid && buf_wr_data == $past(data_in)) else $error("dma word lost");
   a_fault_zero_bits: assert property ($fell(io_read_strobe_n) && io_lo && high_byte_enable_n
      && addr[3:0] == OFF_FAULT |=> data_out[5] == 1'b0 && data_out[3] == 1'b0
      && data_out[1] == 1'b0) else $error("fault spare bit set");
   a_count_range: assert property (transfer_sectors != 9'h000 && transfer_sectors <= FULL_COUNT)
      else $error("count out of range");
   a_done_good_count: assert property (command_done && !command_failed
      |=> transfer_sectors == FULL_COUNT) else $error("count not cleared");
   a_done_fail_count: assert property (command_done && command_failed && remaining_sectors != 0
      |=> transfer_sectors == {1'b0, remaining_sectors}) else $error("count not kept");
   a_status_ack_irq: assert property ($fell(io_read_strobe_n) && io_lo && !interrupt_event
      && addr[3:0] == OFF_COMMAND |=> !interrupt_request) else $error("interrupt kept");
   c_dma_push: cover property (buf_wr_valid && card_mode == MODE_IDE);
   c_fail_done: cover property (command_done && command_failed);
   c_irq_set: cover property ($rose(interrupt_request));
endmodule
bind task_file_address_decoder task_file_checker u_chk (.sys_clk, .srst, .reg_select_n,
   .low_byte_enable_n, .high_byte_enable_n, .io_read_strobe_n, .io_write_strobe_n,
   .dma_grant_n, .command_block_select_n, .control_block_select_n, .interrupt_event,
   .command_done, .command_failed, .interrupt_request, .data_oe_low, .data_oe_high,
   .buf_wr_valid, .command_valid, .card_mode, .addr, .data_in, .data_out, .buf_wr_data,
   .device_flags, .remaining_sectors, .command_code, .transfer_sectors);
`default_nettype wire

// *** host_bus_model.sv ***
// Purpose: Host bus controller that runs one strobed access per call.
// Assumes: Requests change just after a rising edge.
// Notes:   Released write data is driven inverted, never left stale.
`timescale 1ns/10ps
`default_nettype none
module host_bus_model
   import task_file_pkg::*;
(
   input wire logic        sys_clk, data_oe_low, data_oe_high,
   input wire logic [15:0] data_out,
   output var card_mode_t  card_mode,
   output logic            reg_select_n, low_byte_enable_n, high_byte_enable_n,
   output logic            io_read_strobe_n, io_write_strobe_n, mem_read_strobe_n,
   output logic            mem_write_strobe_n, command_block_select_n, control_block_select_n,
   output logic            dma_grant_n,
   output logic [10:0]     addr,
   output logic [15:0]     data_in
);
   initial begin
      card_mode = MODE_IO;
      {reg_select_n, low_byte_enable_n, high_byte_enable_n, io_read_strobe_n} = 4'hf;
      {io_write_strobe_n, mem_read_strobe_n, mem_write_strobe_n} = 3'h7;
      {command_block_select_n, control_block_select_n, dma_grant_n} = 3'h7;
      addr = 11'h000;
      data_in = 16'h0000;
   end
   // ---------------------------------------------------------------
   // One access: q returns {oe_high, oe_low, data_out}
   // ---------------------------------------------------------------
   task automatic xfer(input card_mode_t m, input logic rs, input logic [2:0] sel,
      input logic [10:0] a, input logic [1:0] ce, input logic wr, input logic [15:0] d,
      output logic [17:0] q);
      @(posedge sys_clk);
      card_mode <= m;
      reg_select_n <= rs;
      addr <= a;
      data_in <= d;
      {control_block_select_n, command_block_select_n, dma_grant_n} <= sel;
      {high_byte_enable_n, low_byte_enable_n} <= ce;
      if (m == MODE_MEM) {mem_write_strobe_n, mem_read_strobe_n} <= {!wr, wr};
      else {io_write_strobe_n, io_read_strobe_n} <= {!wr, wr};
      repeat (3) @(posedge sys_clk);
      q = {data_oe_high, data_oe_low, data_out};
      {io_write_strobe_n, io_read_strobe_n, mem_write_strobe_n, mem_read_strobe_n} <= 4'hf;
      {high_byte_enable_n, low_byte_enable_n} <= 2'b11;
      data_in <= ~d;
   endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// Purpose: Directed register-access tests of the task-file decoder.
// Assumes: Card-side status flags are idle and not busy.
// Notes:   Host cycles go through the host bus model.
`timescale 1ns/10ps
`default_nettype none
module tb;
   import task_file_pkg::*;
   logic sys_clk = 1'b0, srst = 1'b1, pio_byte_mode = 1'b0, irq_ev = 1'b0;
   logic cmd_done = 1'b0, cmd_fail = 1'b0;
   logic [4:0] flg = 5'h00;
   logic [7:0] remain = 8'h00;
   logic [15:0] buf_rd_data = 16'hbeef;
   logic [17:0] q;
   int mismatches = 0, num_checks = 0;
   int exp_bit[5] = '{0, 2, 4, 6, 7};
   card_mode_t card_mode;
   wire logic reg_select_n, low_byte_enable_n, high_byte_enable_n, io_read_strobe_n;
   wire logic io_write_strobe_n, mem_read_strobe_n, mem_write_strobe_n, dma_grant_n;
   wire logic command_block_select_n, control_block_select_n, data_oe_low, data_oe_high;
   wire logic logical_block_mode, interrupt_request;
   wire logic [10:0] addr;
   wire logic [15:0] data_in, data_out;
   wire logic [7:0] command_option;
   wire logic [8:0] transfer_sectors;
   wire logic [27:0] start_address;
   always #5 sys_clk = ~sys_clk;
   host_bus_model u_host (.sys_clk, .data_oe_low, .data_oe_high, .data_out, .card_mode,
      .reg_select_n, .low_byte_enable_n, .high_byte_enable_n, .io_read_strobe_n,
      .io_write_strobe_n, .mem_read_strobe_n, .mem_write_strobe_n, .command_block_select_n,
      .control_block_select_n, .dma_grant_n, .addr, .data_in);
   task_file_address_decoder u_dut (.sys_clk, .srst, .card_mode, .reg_select_n, .addr,
      .low_byte_enable_n, .high_byte_enable_n, .io_read_strobe_n, .io_write_strobe_n,
      .mem_read_strobe_n, .mem_write_strobe_n, .command_block_select_n,
      .control_block_select_n, .dma_grant_n, .data_in, .pio_byte_mode, .buf_rd_data,
      .device_flags(6'h10), .write_gate(1'b0), .bad_block_or_crc_flag(flg[4]),
      .uncorrectable_flag(flg[3]), .sector_id_missing_flag(flg[2]),
      .command_aborted_flag(flg[1]), .general_error_flag(flg[0]), .command_done(cmd_done),
      .command_failed(cmd_fail), .remaining_sectors(remain), .interrupt_event(irq_ev),
      .data_out, .data_oe_low, .data_oe_high, .buf_wr_data(), .buf_wr_valid(),
      .buf_rd_pop(), .command_code(), .command_valid(), .command_option,
      .transfer_sectors, .start_address, .logical_block_mode, .unit_select(),
      .soft_reset(), .interrupt_request);
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic io(input logic [3:0] off, input logic wr, input logic [15:0] d,
      input logic [1:0] ce = 2'b10);
      u_host.xfer(MODE_IO, 1'b0, 3'b111, {7'h00, off}, ce, wr, d, q);
   endtask
   task automatic ide(input logic [2:0] sel, input logic [3:0] off, input logic wr);
      u_host.xfer(MODE_IDE, 1'b1, sel, {7'h00, off}, 2'b11, wr, 16'h1234, q);
   endtask
   task automatic card(input logic [4:0] f, input logic d, input logic e, input logic i);
      @(posedge sys_clk);
      {flg, cmd_done, cmd_fail, irq_ev} <= {f, d, e, i};
      @(posedge sys_clk);
      {flg, cmd_done, irq_ev} <= 7'h00;
      @(negedge sys_clk);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      results();
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      @(negedge sys_clk);
      check({7'h00, transfer_sectors}, 16'h0100);
      for (int i = 2; i < 6; i++) begin
         io(i[3:0], 1'b1, 16'h0010 + 16'(i));
         io(i[3:0], 1'b0, 16'h0000);
         check({q[16], 7'h00, q[7:0]}, 16'h8010 + 16'(i));
      end
      check(start_address[15:0], 16'h1413);
      check({8'h00, start_address[23:16]}, 16'h0015);
      io(4'h2, 1'b1, 16'h0000);
      check({7'h00, transfer_sectors}, 16'h0100);
      io(4'h6, 1'b1, 16'h00e5);
      check({11'h000, logical_block_mode, start_address[27:24]}, 16'h0015);
      io(4'hf, 1'b0, 16'h0000);
      check({8'h00, q[7:0]}, 16'h006a);
      u_host.xfer(MODE_MEM, 1'b1, 3'b111, 11'h3f3, 2'b10, 1'b1, 16'h005a, q);
      io(4'h3, 1'b0, 16'h0000);
      check({8'h00, q[7:0]}, 16'h005a);
      u_host.xfer(MODE_MEM, 1'b1, 3'b111, 11'h400, 2'b00, 1'b0, 16'h0000, q);
      check(q[15:0], 16'hbeef);
      io(4'h8, 1'b0, 16'h0000, 2'b00);
      check({q[17:16], q[13:0]}, 16'hfeef);
      io(4'h0, 1'b0, 16'h0000, 2'b10);
      check({q[17:16], 6'h00, q[7:0]}, 16'h40ef);
      io(4'h9, 1'b0, 16'h0000, 2'b01);
      check({q[17:16], 6'h00, q[15:8]}, 16'h80be);
      io(4'h1, 1'b1, 16'h003c);
      check({8'h00, command_option}, 16'h003c);
      io(4'h0, 1'b1, 16'hc300, 2'b01);
      check({8'h00, command_option}, 16'h00c3);
      for (int k = 0; k < 5; k++) begin
         io(4'h7, 1'b1, 16'h0000);
         card(5'h01 << k, 1'b0, 1'b0, 1'b0);
         io(4'h1, 1'b0, 16'h0000);
         check({8'h00, q[7:0]}, 16'h0001 << exp_bit[k]);
         io(4'hd, 1'b0, 16'h0000);
         check({8'h00, q[7:0]}, 16'h0001 << exp_bit[k]);
         io(4'h0, 1'b0, 16'h0000, 2'b01);
         check({8'h00, q[15:8]}, 16'h0001 << exp_bit[k]);
      end
      card(5'h00, 1'b1, 1'b1, 1'b0);
      check({7'h00, transfer_sectors}, 16'h0100);
      @(posedge sys_clk) remain <= 8'h05;
      card(5'h00, 1'b1, 1'b1, 1'b0);
      check({7'h00, transfer_sectors}, 16'h0005);
      io(4'h7, 1'b0, 16'h0000);
      check({15'h0000, q[0]}, 16'h0001);
      card(5'h00, 1'b1, 1'b0, 1'b0);
      check({7'h00, transfer_sectors}, 16'h0100);
      card(5'h00, 1'b0, 1'b0, 1'b1);
      check({15'h0000, interrupt_request}, 16'h0001);
      io(4'he, 1'b0, 16'h0000);
      check({15'h0000, interrupt_request}, 16'h0001);
      io(4'h7, 1'b0, 16'h0000);
      check({15'h0000, interrupt_request}, 16'h0000);
      ide(3'b101, 4'h3, 1'b0);
      check({8'h00, q[7:0]}, 16'h005a);
      ide(3'b011, 4'h6, 1'b0);
      check({q[16], 7'h00, q[7:0]}, 16'h8041);
      ide(3'b110, 4'h5, 1'b0);
      check(q[15:0], 16'hbeef);
      ide(3'b110, 4'h2, 1'b1);
      pio_byte_mode <= 1'b1;
      ide(3'b101, 4'h0, 1'b0);
      check({q[17:16], 6'h00, q[7:0]}, 16'h40ef);
      io(4'ha, 1'b1, 16'h00ff);
      io(4'ha, 1'b0, 16'h0000);
      check({8'h00, q[7:0]}, 16'h0000);
      u_host.xfer(MODE_IO, 1'b1, 3'b111, 11'h002, 2'b10, 1'b0, 16'h0000, q);
      check({14'h0000, q[17:16]}, 16'h0000);
      io(4'h2, 1'b0, 16'h0000, 2'b11);
      check({14'h0000, q[17:16]}, 16'h0000);
      results();
   end
endmodule
`default_nettype wire
